/* pkg/ampi2_pkg.sv */
/*
 Package of constants shared by both ends of the amplifier control port.
 Assumes a single 10 MHz system clock on each end.
*/
package ampi2_pkg;
    localparam logic [5:0] ADDR_BASE = 6'h36;
    localparam logic [7:0] REG_IDENT = 8'h00;
    // Identity code returned by the ident register; the value is arbitrary.
    localparam logic [7:0] IDENT_CODE = 8'h5c;
    localparam logic [7:0] REG_POWER = 8'h01;
    localparam logic [7:0] REG_DIGITAL = 8'h02;
    localparam logic [7:0] REG_VOLCFG = 8'h03;
    localparam logic [7:0] REG_LEFTVOL = 8'h04;
    localparam logic [7:0] REG_RIGHTVOL = 8'h05;
    localparam logic [7:0] REG_ANALOG = 8'h06;
    localparam logic [7:0] REG_RSVD7 = 8'h07;
    localparam logic [7:0] REG_FAULT = 8'h08;
    localparam logic [7:0] REG_CLIPMID = 8'h10;
    localparam logic [7:0] REG_CLIPLOW = 8'h11;
    localparam logic [7:0] RST_POWER = 8'hfd;
    localparam logic [7:0] RST_DIGITAL = 8'h14;
    localparam logic [7:0] RST_VOLCFG = 8'h80;
    localparam logic [7:0] RST_VOL = 8'hcf;
    localparam logic [7:0] RST_ANALOG = 8'h51;
    localparam logic [7:0] RST_FAULT = 8'h00;
    localparam logic [7:0] RST_CLIPMID = 8'hff;
    localparam logic [7:0] RST_CLIPLOW = 8'hfc;
    localparam logic [7:0] MASK_DIGITAL = 8'hbf;
    localparam logic [7:0] MASK_VOLCFG = 8'h83;
    localparam logic [7:0] MASK_ANALOG = 8'hfe;
    localparam logic [7:0] MASK_FAULT = 8'h30;
    localparam int CLK_HZ = 10_000_000;
    localparam int SCL_HZ = 100_000;
    localparam int QTR_CYC = CLK_HZ / (SCL_HZ * 4);
    localparam logic [3:0] BIT_LAST = 4'h7;
endpackage

/* pkg/ampi2_if.sv */
/*
 Two-wire bus between the amplifier port and its master.
 Assumes external pull-ups: a line is low whenever any party enables its drive.
*/
interface ampi2_if;
    logic scl_oe_m;
    logic sda_oe_m;
    logic sda_oe_s;
    wire scl = ~scl_oe_m;
    wire sda = ~(sda_oe_m | sda_oe_s);
    modport dev (input scl, input sda, output sda_oe_s);
    modport mst (input scl, input sda, output scl_oe_m, output sda_oe_m);
endinterface

/* src/ampi2_dev.sv */
/*
 Target end of the amplifier control port with its register file.
 Assumes SCL and SDA are asynchronous pins sampled on clk_i.
*/
module ampi2_dev (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic sleep_addr_strap_pin_i,
    ampi2_if.dev bus,
    output logic [7:0] power_ctrl_o,
    output logic [7:0] digital_ctrl_o,
    output logic [7:0] volume_config_o,
    output logic [7:0] left_volume_o,
    output logic [7:0] right_volume_o,
    output logic [7:0] analog_ctrl_o,
    output logic [7:0] clip_level_mid_o,
    output logic [7:0] clip_level_low_o,
    input wire logic [3:0] fault_flags_i
);
    import ampi2_pkg::*;

    typedef enum logic [2:0] {
        AMPI2_IDLE = 3'b000,
        AMPI2_ADDR = 3'b001,
        AMPI2_ACK = 3'b011,
        AMPI2_RX = 3'b010,
        AMPI2_TX = 3'b110,
        AMPI2_MACK = 3'b111
    } ampi2_state_t;

    // ------------------------------------------------------------
    // Pin synchronisers and condition detection
    // ------------------------------------------------------------
    logic [1:0] scl_s_q, sda_s_q;
    logic scl_p_q, sda_p_q;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], bus.scl};
            sda_s_q <= {sda_s_q[0], bus.sda};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
        end
    end
    wire scl_w = scl_s_q[1];
    wire sda_w = sda_s_q[1];
    wire scl_rise = scl_w & ~scl_p_q;
    wire scl_fall = ~scl_w & scl_p_q;
    wire start_w = scl_w & scl_p_q & sda_p_q & ~sda_w;
    wire stop_w = scl_w & scl_p_q & ~sda_p_q & sda_w;

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    ampi2_state_t st_q, st_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
    logic [3:0] cnt_q, cnt_d;
    logic rd_q, rd_d, ack_q, ack_d, gotp_q, gotp_d, oe_q, oe_d, strap_q, strap_d;
    logic wr_en;
    logic [7:0] rdata;
    logic [7:0] fault_q;

    function automatic logic [7:0] rd_reg(input logic [7:0] a);
        unique case (a)
            REG_IDENT: rd_reg = IDENT_CODE;
            REG_POWER: rd_reg = power_ctrl_o;
            REG_DIGITAL: rd_reg = digital_ctrl_o;
            REG_VOLCFG: rd_reg = volume_config_o;
            REG_LEFTVOL: rd_reg = left_volume_o;
            REG_RIGHTVOL: rd_reg = right_volume_o;
            REG_ANALOG: rd_reg = analog_ctrl_o;
            REG_FAULT: rd_reg = {2'h0, fault_q[5:4], fault_flags_i};
            REG_CLIPMID: rd_reg = clip_level_mid_o;
            REG_CLIPLOW: rd_reg = clip_level_low_o;
            default: rd_reg = 8'h00;
        endcase
    endfunction

    assign rdata = rd_reg(ptr_q);

    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        cnt_d = cnt_q;
        rd_d = rd_q;
        ack_d = ack_q;
        gotp_d = gotp_q;
        oe_d = oe_q;
        wr_en = 1'b0;
        if (start_w) begin
            st_d = AMPI2_ADDR;
            cnt_d = 4'h0;
            gotp_d = 1'b0;
            oe_d = 1'b0;
        end else if (stop_w) begin
            st_d = AMPI2_IDLE;
            oe_d = 1'b0;
        end else begin
            unique case (st_q)
                AMPI2_IDLE: oe_d = 1'b0;
                AMPI2_ADDR, AMPI2_RX: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_w};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BIT_LAST + 4'h1) begin
                        cnt_d = 4'h0;
                        if (st_q == AMPI2_ADDR) begin
                            ack_d = sh_q[7:1] == {ADDR_BASE, strap_q};
                            rd_d = sh_q[0];
                        end else begin
                            ack_d = 1'b1;
                            if (!gotp_q) begin
                                ptr_d = sh_q;
                                gotp_d = 1'b1;
                            end else begin
                                wr_en = 1'b1;
                                ptr_d = ptr_q + 8'h01;
                            end
                        end
                        oe_d = ack_d;
                        st_d = ack_d ? AMPI2_ACK : AMPI2_IDLE;
                    end
                end
                AMPI2_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rd_q) begin
                            sh_d = rdata;
                            oe_d = ~rdata[7];
                            st_d = AMPI2_TX;
                        end else begin
                            oe_d = 1'b0;
                            st_d = AMPI2_RX;
                        end
                    end
                end
                AMPI2_TX: begin
                    if (scl_fall) begin
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == BIT_LAST) begin
                            oe_d = 1'b0;
                            ptr_d = ptr_q + 8'h01;
                            st_d = AMPI2_MACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = ~sh_q[6];
                        end
                    end
                end
                AMPI2_MACK: begin
                    if (scl_rise) begin
                        st_d = sda_w ? AMPI2_IDLE : AMPI2_ACK;
                    end
                end
                default: st_d = AMPI2_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_q <= AMPI2_IDLE;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            cnt_q <= 4'h0;
            rd_q <= 1'b0;
            ack_q <= 1'b0;
            gotp_q <= 1'b0;
            oe_q <= 1'b0;
            strap_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            ack_q <= ack_d;
            gotp_q <= gotp_d;
            oe_q <= oe_d;
            strap_q <= strap_d;
        end
    end

    // ------------------------------------------------------------
    // Strap capture one cycle after reset release
    // ------------------------------------------------------------
    logic strap_done_q;
    logic [1:0] strap_s_q;
    // The strap synchroniser runs through reset so it is settled at release.
    always_ff @(posedge clk_i) begin
        strap_s_q <= {strap_s_q[0], sleep_addr_strap_pin_i};
    end
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            strap_done_q <= 1'b0;
        end else begin
            strap_done_q <= 1'b1;
        end
    end
    assign strap_d = strap_done_q ? strap_q : strap_s_q[1];
    assign bus.sda_oe_s = oe_q;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            power_ctrl_o <= RST_POWER;
            digital_ctrl_o <= RST_DIGITAL;
            volume_config_o <= RST_VOLCFG;
            left_volume_o <= RST_VOL;
            right_volume_o <= RST_VOL;
            analog_ctrl_o <= RST_ANALOG;
            fault_q <= RST_FAULT;
            clip_level_mid_o <= RST_CLIPMID;
            clip_level_low_o <= RST_CLIPLOW;
        end else if (wr_en) begin
            unique case (ptr_q)
                REG_POWER: power_ctrl_o <= sh_q;
                REG_DIGITAL: digital_ctrl_o <= (sh_q & MASK_DIGITAL);
                REG_VOLCFG: volume_config_o <= (sh_q & MASK_VOLCFG);
                REG_LEFTVOL: left_volume_o <= sh_q;
                REG_RIGHTVOL: right_volume_o <= sh_q;
                REG_ANALOG: analog_ctrl_o <= (sh_q & MASK_ANALOG) | 8'h01;
                REG_FAULT: fault_q <= sh_q & MASK_FAULT;
                REG_CLIPMID: clip_level_mid_o <= sh_q;
                REG_CLIPLOW: clip_level_low_o <= sh_q;
                default: ;
            endcase
        end
    end
endmodule

/* src/ampi2_mst.sv */
/*
 Master end: runs one register write or one register read per command.
 Assumes cmd_valid_i is a one-cycle pulse accepted only while busy_o is low.
*/
module ampi2_mst (
    input wire logic clk_i,
    input wire logic nrst_i,
    ampi2_if.mst bus,
    input wire logic cmd_valid_i,
    input wire logic cmd_read_i,
    input wire logic [6:0] cmd_dev_i,
    input wire logic [7:0] cmd_reg_i,
    input wire logic [7:0] cmd_wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic nack_o,
    output logic [7:0] rdata_o
);
    import ampi2_pkg::*;

    typedef enum logic [2:0] {
        AMPI2M_IDLE = 3'b000,
        AMPI2M_START = 3'b001,
        AMPI2M_BYTE = 3'b011,
        AMPI2M_STOP = 3'b010,
        AMPI2M_DONE = 3'b110
    } ampi2m_state_t;

    // ------------------------------------------------------------
    // Quarter-bit enable and SDA sampling
    // ------------------------------------------------------------
    logic [7:0] div_q;
    wire tick = div_q == 8'(QTR_CYC - 1);
    always_ff @(posedge clk_i) begin
        if (!nrst_i) div_q <= 8'h00;
        else div_q <= tick ? 8'h00 : div_q + 8'h01;
    end
    logic [1:0] sda_s_q;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) sda_s_q <= 2'h3;
        else sda_s_q <= {sda_s_q[0], bus.sda};
    end

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    ampi2m_state_t st_q, st_d;
    logic [1:0] ph_q, ph_d, idx_q, idx_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, rd_q, rd_d;
    logic scl_q, scl_d, sda_q, sda_d, nack_q, nack_d, done_d;
    logic rdop_q, rdop_d;
    logic [6:0] dev_q, dev_d;
    logic [7:0] reg_q, reg_d, wd_q, wd_d;
    // Byte sequence: 0 addr+W, 1 register, 2 data or addr+R after restart, 3 read data.
    function automatic logic [7:0] byte_of(input logic [1:0] i, input logic r,
            input logic [6:0] d, input logic [7:0] g, input logic [7:0] w);
        unique case (i)
            2'd0: byte_of = {d, 1'b0};
            2'd1: byte_of = g;
            2'd2: byte_of = r ? {d, 1'b1} : w;
            default: byte_of = 8'hff;
        endcase
    endfunction

    always_comb begin
        st_d = st_q; ph_d = ph_q; idx_d = idx_q; bit_d = bit_q; sh_d = sh_q;
        rd_d = rd_q; scl_d = scl_q; sda_d = sda_q; nack_d = nack_q;
        rdop_d = rdop_q; dev_d = dev_q; reg_d = reg_q; wd_d = wd_q; done_d = 1'b0;
        unique case (st_q)
            AMPI2M_IDLE: begin
                if (cmd_valid_i) begin
                    rdop_d = cmd_read_i; dev_d = cmd_dev_i;
                    reg_d = cmd_reg_i; wd_d = cmd_wdata_i;
                    idx_d = 2'd0; nack_d = 1'b0; ph_d = 2'd0;
                    st_d = AMPI2M_START;
                end
            end
            AMPI2M_START: if (tick) begin
                ph_d = ph_q + 2'd1;
                if (ph_q == 2'd0) begin scl_d = 1'b1; sda_d = 1'b1; end
                if (ph_q == 2'd1) sda_d = 1'b0;
                if (ph_q == 2'd3) begin
                    scl_d = 1'b0; bit_d = 4'h0; ph_d = 2'd0;
                    sh_d = byte_of(idx_q, rdop_q, dev_q, reg_q, wd_q);
                    st_d = AMPI2M_BYTE;
                end
            end
            AMPI2M_BYTE: if (tick) begin
                ph_d = ph_q + 2'd1;
                unique case (ph_q)
                    2'd0: sda_d = (bit_q == 4'h8) ? 1'b1 : sh_q[7];
                    2'd1: scl_d = 1'b1;
                    2'd2: begin
                        if (bit_q == 4'h8) begin
                            if (idx_q != 2'd3 && sda_s_q[1]) nack_d = 1'b1;
                        end else begin
                            rd_d = {rd_q[6:0], sda_s_q[1]};
                        end
                    end
                    default: begin
                        scl_d = 1'b0; sh_d = {sh_q[6:0], 1'b1};
                        bit_d = bit_q + 4'h1;
                        if (bit_q == 4'h8) begin
                            bit_d = 4'h0;
                            if (nack_q || idx_q == 2'd3 || (idx_q == 2'd2 && !rdop_q)) begin
                                st_d = AMPI2M_STOP;
                            end else if (idx_q == 2'd1 && rdop_q) begin
                                idx_d = 2'd2; st_d = AMPI2M_START;
                            end else begin
                                idx_d = idx_q + 2'd1;
                                sh_d = byte_of(idx_d, rdop_q, dev_q, reg_q, wd_q);
                            end
                        end
                    end
                endcase
            end
            AMPI2M_STOP: if (tick) begin
                ph_d = ph_q + 2'd1;
                if (ph_q == 2'd0) sda_d = 1'b0;
                if (ph_q == 2'd1) scl_d = 1'b1;
                if (ph_q == 2'd3) begin sda_d = 1'b1; st_d = AMPI2M_DONE; end
            end
            AMPI2M_DONE: begin done_d = 1'b1; st_d = AMPI2M_IDLE; end
            default: st_d = AMPI2M_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_q <= AMPI2M_IDLE; ph_q <= 2'd0; idx_q <= 2'd0; bit_q <= 4'h0;
            sh_q <= 8'h00; rd_q <= 8'h00; scl_q <= 1'b1; sda_q <= 1'b1;
            nack_q <= 1'b0; rdop_q <= 1'b0; dev_q <= 7'h00; reg_q <= 8'h00;
            wd_q <= 8'h00; busy_o <= 1'b0; done_o <= 1'b0; nack_o <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            st_q <= st_d; ph_q <= ph_d; idx_q <= idx_d; bit_q <= bit_d;
            sh_q <= sh_d; rd_q <= rd_d; scl_q <= scl_d; sda_q <= sda_d;
            nack_q <= nack_d; rdop_q <= rdop_d; dev_q <= dev_d; reg_q <= reg_d;
            wd_q <= wd_d; busy_o <= st_d != AMPI2M_IDLE; done_o <= done_d;
            if (done_d) begin nack_o <= nack_q; rdata_o <= rd_q; end
        end
    end
    assign bus.scl_oe_m = ~scl_q;
    assign bus.sda_oe_m = ~sda_q;
endmodule

/* test/ampi2_monitor.sv */
/*
 Checker for the two-wire bus between the amplifier port and its master.
 Assumes it sees the interface nets plus the device clock, reset and strap.
*/
module ampi2_monitor (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic sleep_addr_strap_pin_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_oe_m,
    input wire logic sda_oe_m,
    input wire logic sda_oe_s
);
    timeunit 1ns;
    timeprecision 1ns;
    import ampi2_pkg::*;
    // ------------------------------------------------------------
    // Bus tracker
    // ------------------------------------------------------------
    logic scl_q, sda_q, strap_q, first_q, sel_q, rd_q;
    logic first_d, sel_d, rd_d, rise, start_ev, stop_ev, addr_ok;
    logic [3:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d;
    always_comb begin
        rise = scl && !scl_q;
        start_ev = scl && scl_q && sda_q && !sda;
        stop_ev = scl && scl_q && !sda_q && sda;
        addr_ok = shift_q[7:1] == {ADDR_BASE, strap_q};
        bit_d = bit_q;
        shift_d = shift_q;
        first_d = first_q;
        sel_d = sel_q;
        rd_d = rd_q;
        if (start_ev || stop_ev) begin
            bit_d = 4'h0;
            first_d = 1'b1;
            sel_d = 1'b0;
            rd_d = 1'b0;
        end else if (rise && bit_q == 4'h8) begin
            bit_d = 4'h0;
            first_d = 1'b0;
            sel_d = first_q ? addr_ok : sel_q;
            rd_d = first_q ? (addr_ok && shift_q[0]) : rd_q;
        end else if (rise) begin
            bit_d = bit_q + 4'h1;
            shift_d = {shift_q[6:0], sda};
        end
    end
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            strap_q <= sleep_addr_strap_pin_i;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            first_q <= 1'b1;
            sel_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            bit_q <= bit_d;
            shift_q <= shift_d;
            first_q <= first_d;
            sel_q <= sel_d;
            rd_q <= rd_d;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_ack;
        rise && bit_q == 4'h8;
    endsequence
    sequence s_data;
        rise && bit_q != 4'h8;
    endsequence
    AST_ADDR_ACK: assert property (s_ack ##0 (first_q && addr_ok) |-> sda_oe_s)
        else $error("matching address not acknowledged");
    AST_ADDR_IGNORE: assert property (s_ack ##0 (first_q && !addr_ok) |-> !sda_oe_s)
        else $error("foreign address acknowledged");
    AST_DATA_ACK: assert property (s_ack ##0 (!first_q && sel_q && !rd_q) |-> sda_oe_s)
        else $error("received byte not acknowledged");
    AST_READ_RELEASE: assert property (s_ack ##0 rd_q |-> !sda_oe_s)
        else $error("device held data line in master acknowledge slot");
    AST_WRITE_QUIET: assert property (s_data ##0 !rd_q |-> !sda_oe_s)
        else $error("device drove a data bit it should receive");
    AST_ACK_STEADY: assert property (rise && sda_oe_s |-> sda_oe_s [*8])
        else $error("device drive dropped while clock high");
    AST_CHANGE_LOW: assert property ($changed(sda_oe_s) |-> !scl)
        else $error("device changed data line while clock high");
    AST_STOP_RELEASE: assert property (stop_ev |-> !sda_oe_s [*8])
        else $error("device drove bus after stop");
    AST_NO_INITIATE: assert property (first_q && bit_q != 4'h8 |-> !sda_oe_s)
        else $error("device drove data line before being addressed");
    AST_UNSEL_QUIET: assert property (!first_q && !sel_q |-> !sda_oe_s)
        else $error("unaddressed device drove data line");
    AST_ACK_ALONE: assert property (s_ack ##0 sda_oe_s |-> !sda_oe_m)
        else $error("master drove data line during device acknowledge");
endmodule

/* test/amp_i2c_control_port_tb.sv */
/*
 Self-checking bench joining both ends of the amplifier control port.
 Assumes the package, interface, both ends and the monitor compile first.
*/
module amp_i2c_control_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ampi2_pkg::*;
    typedef struct packed {
        logic rd;
        logic [6:0] dev;
        logic [7:0] rg;
        logic [7:0] wd;
        logic [7:0] exp;
        logic nack;
    } ampi2_row_t;
    localparam logic [6:0] DEV_HI = {ADDR_BASE, 1'b1};
    localparam logic [6:0] DEV_LO = {ADDR_BASE, 1'b0};
    logic clk_i = 1'b0;
    logic nrst_i, strap, cmd_valid_i, cmd_read_i, busy_o, done_o, nack_o;
    logic [3:0] fault_flags;
    logic [6:0] cmd_dev_i;
    logic [7:0] cmd_reg_i, cmd_wdata_i, rdata_o, pw, dg, vc, lv, rv, an, cm, cl;
    logic [63:0] regs;
    int num_errors = 0;
    int comparisons = 0;
    ampi2_row_t rows [0:17];
    always #50 clk_i = ~clk_i;
    ampi2_if bus ();
    ampi2_dev u_ampi2_dev (.clk_i(clk_i), .nrst_i(nrst_i), .sleep_addr_strap_pin_i(strap),
        .bus(bus), .power_ctrl_o(pw), .digital_ctrl_o(dg), .volume_config_o(vc),
        .left_volume_o(lv), .right_volume_o(rv), .analog_ctrl_o(an), .clip_level_mid_o(cm),
        .clip_level_low_o(cl), .fault_flags_i(fault_flags));
    ampi2_mst u_ampi2_mst (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus), .cmd_valid_i(cmd_valid_i),
        .cmd_read_i(cmd_read_i), .cmd_dev_i(cmd_dev_i), .cmd_reg_i(cmd_reg_i),
        .cmd_wdata_i(cmd_wdata_i), .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o),
        .rdata_o(rdata_o));
    ampi2_monitor u_ampi2_monitor (.clk_i(clk_i), .nrst_i(nrst_i), .sleep_addr_strap_pin_i(strap),
        .scl(bus.scl), .sda(bus.sda), .scl_oe_m(bus.scl_oe_m), .sda_oe_m(bus.sda_oe_m),
        .sda_oe_s(bus.sda_oe_s));
    assign regs = {pw, dg, vc, lv, rv, an, cm, cl};
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic do_reset();
        nrst_i = 1'b0;
        repeat (5) @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
    endtask
    // A second request is pulsed mid-transfer; the master must ignore it.
    task automatic run_row(input ampi2_row_t r);
        int n;
        {cmd_read_i, cmd_dev_i, cmd_reg_i, cmd_wdata_i} = {r.rd, r.dev, r.rg, r.wd};
        cmd_valid_i = 1'b1;
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
        repeat (200) @(negedge clk_i);
        cmd_valid_i = 1'b1;
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 6000) begin
            @(negedge clk_i);
            n++;
        end
        check("done", 64'h1, 64'(done_o));
        check("nack", 64'(r.nack), 64'(nack_o));
        if (r.rd) check("rdata", 64'(r.exp), 64'(rdata_o));
        repeat (2) @(negedge clk_i);
        check("busy", 64'h0, 64'(busy_o));
        check("idle lines", 64'h3, {62'h0, bus.scl, bus.sda});
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        num_errors++;
        $display("FAIL watchdog expected done seen hang");
        final_report();
    end
    initial begin
        {nrst_i, cmd_valid_i, cmd_read_i, cmd_dev_i, cmd_reg_i, cmd_wdata_i} = '0;
        strap = 1'b1;
        fault_flags = 4'h9;
        rows[0] = '{1'b1, DEV_HI, REG_IDENT, 8'h00, IDENT_CODE, 1'b0};
        rows[1] = '{1'b1, DEV_HI, REG_POWER, 8'h00, 8'hfd, 1'b0};
        rows[2] = '{1'b0, DEV_HI, REG_POWER, 8'ha5, 8'h00, 1'b0};
        rows[3] = '{1'b0, DEV_HI, REG_DIGITAL, 8'hff, 8'h00, 1'b0};
        rows[4] = '{1'b0, DEV_HI, REG_VOLCFG, 8'hff, 8'h00, 1'b0};
        rows[5] = '{1'b0, DEV_HI, REG_ANALOG, 8'h80, 8'h00, 1'b0};
        rows[6] = '{1'b0, DEV_HI, REG_FAULT, 8'hff, 8'h00, 1'b0};
        rows[7] = '{1'b0, DEV_HI, REG_RSVD7, 8'hff, 8'h00, 1'b0};
        rows[8] = '{1'b0, DEV_HI, REG_CLIPLOW, 8'h5a, 8'h00, 1'b0};
        rows[9] = '{1'b0, DEV_LO, REG_POWER, 8'h00, 8'h00, 1'b1};
        rows[10] = '{1'b1, DEV_HI, REG_POWER, 8'h00, 8'ha5, 1'b0};
        rows[11] = '{1'b1, DEV_HI, REG_DIGITAL, 8'h00, 8'hff & MASK_DIGITAL, 1'b0};
        rows[12] = '{1'b1, DEV_HI, REG_VOLCFG, 8'h00, 8'hff & MASK_VOLCFG, 1'b0};
        rows[13] = '{1'b1, DEV_HI, REG_ANALOG, 8'h00, (8'h80 & MASK_ANALOG) | 8'h01, 1'b0};
        rows[14] = '{1'b1, DEV_HI, REG_FAULT, 8'h00, (8'hff & MASK_FAULT) | 8'h09, 1'b0};
        rows[15] = '{1'b1, DEV_HI, REG_RSVD7, 8'h00, 8'h00, 1'b0};
        rows[16] = '{1'b1, DEV_HI, 8'h09, 8'h00, 8'h00, 1'b0};
        rows[17] = '{1'b1, DEV_HI, REG_CLIPLOW, 8'h00, 8'h5a, 1'b0};
        do_reset();
        check("reset regs", 64'hfd14_80cf_cf51_fffc, regs);
        foreach (rows[i]) run_row(rows[i]);
        check("final regs", 64'ha5bf_83cf_cf81_ff5a, regs);
        strap = 1'b0;
        do_reset();
        check("rereset regs", 64'hfd14_80cf_cf51_fffc, regs);
        run_row('{1'b1, DEV_LO, REG_POWER, 8'h00, 8'hfd, 1'b0});
        run_row('{1'b0, DEV_HI, REG_POWER, 8'h00, 8'h00, 1'b1});
        final_report();
    end
endmodule
